// [dwdt_map.svh]
`ifndef DWDT_MAP_SVH
`define DWDT_MAP_SVH
`define DWDT_REG_ADDR      8'hd8
`define DWDT_REG_RESET     8'hfe
`define DWDT_BIT_ACT       0
`define DWDT_BIT_SR        1
`define DWDT_PRESCALE      3072
`define DWDT_RESET_DELAY   2048
`endif

// [dwdt_pkg.sv]
package dwdt_pkg;
  typedef enum logic [1:0] {
    DWDT_RUN,
    DWDT_STOPPED,
    DWDT_RESETTING
  } dwdt_state_t;
endpackage : dwdt_pkg

// [dwdt_rst_delay.sv]
`include "dwdt_map.svh"
module dwdt_rst_delay #(
  parameter int CYCLES = `DWDT_RESET_DELAY
) (
  input  wire logic ref_clk,
  input  wire logic reset,
  input  wire logic trigger,
  output logic      busy
);
  localparam int W = $clog2(CYCLES + 1);
  initial begin
    if (CYCLES < 1) $error("CYCLES must be at least 1");
  end
  logic [W-1:0] cnt_q;
  wire          run_w = (cnt_q != '0);
  always_ff @(posedge ref_clk) begin
    if (reset) begin
      cnt_q <= '0;
    end else if (trigger) begin
      cnt_q <= W'(CYCLES);
    end else if (run_w) begin
      cnt_q <= cnt_q - W'(1);
    end
  end
  assign busy = run_w | trigger;
endmodule : dwdt_rst_delay

// [dwdt_watchdog.sv]
`include "dwdt_map.svh"
module dwdt_watchdog #(
  parameter int PRESCALE    = `DWDT_PRESCALE,
  parameter int RESET_DELAY = `DWDT_RESET_DELAY
) (
  input  wire logic       ref_clk,
  input  wire logic       reset,
  input  wire logic       hw_activation,
  input  wire logic       ext_stop_ctrl,
  input  wire logic       nmi_pin,
  input  wire logic       stop_exec,
  input  wire logic       wake_irq,
  input  wire logic [7:0] addr,
  input  wire logic       wr_en,
  input  wire logic       rd_en,
  input  wire logic [7:0] wr_data,
  output logic      [7:0] rd_data,
  output logic            rd_hit,
  output logic            osc_stop,
  output logic            core_wait,
  output logic            wdt_reset
);
  initial begin
    if (PRESCALE < 1) $error("PRESCALE must be at least 1");
  end

  ////////////////////////////////////////////////////////////////////////////
  // Bit order helpers
  function automatic logic [6:0] dwdt_to_cnt(input logic [7:0] r);
    // Register bits 7..2 become counter bits 0..5, soft reset bit is bit 6
    dwdt_to_cnt = {r[`DWDT_BIT_SR], r[2], r[3], r[4], r[5], r[6], r[7]};
  endfunction : dwdt_to_cnt

  function automatic logic [7:0] dwdt_to_reg(input logic [6:0] c, input logic a);
    dwdt_to_reg = {c[0], c[1], c[2], c[3], c[4], c[5], c[6], a};
  endfunction : dwdt_to_reg

  ////////////////////////////////////////////////////////////////////////////
  // State
  localparam int PW = $clog2(PRESCALE + 1);
  localparam logic [7:0] RST_VAL = `DWDT_REG_RESET;

  logic [6:0]           cnt_q;
  logic                 act_q;
  logic [PW-1:0]        pre_q;
  logic                 hold_rst;
  dwdt_pkg::dwdt_state_t st_q;
  dwdt_pkg::dwdt_state_t st_d;

  wire reg_sel  = (addr == `DWDT_REG_ADDR);
  wire reg_wr   = wr_en & reg_sel & (st_q != dwdt_pkg::DWDT_RESETTING);
  wire active   = act_q | hw_activation;
  wire frozen   = (st_q == dwdt_pkg::DWDT_STOPPED);
  wire pre_tick = (pre_q == PW'(PRESCALE - 1)) & ~frozen;
  wire [6:0] cnt_dec = cnt_q - 7'h01;
  wire [6:0] cnt_wr  = dwdt_to_cnt(wr_data);
  // Soft reset bit falling from one to zero, by write or by counting
  wire sr_fall = cnt_q[6] & ((reg_wr & ~cnt_wr[6]) | (~reg_wr & pre_tick & ~cnt_dec[6]));
  // Zero reached with the watchdog armed
  wire hit_zero = active & ~reg_wr & pre_tick & (cnt_dec == 7'h00);
  wire trip     = active & (sr_fall | hit_zero);
  // Stop freezes when the watchdog is not active, or with external control and NMI high; otherwise it is a wait
  wire stop_ok  = ~active | (ext_stop_ctrl & nmi_pin);

  ////////////////////////////////////////////////////////////////////////////
  // Reset stretch
  dwdt_rst_delay #(
    .CYCLES (RESET_DELAY)
  ) u_delay (
    .ref_clk (ref_clk),
    .reset   (reset),
    .trigger (trip),
    .busy    (hold_rst)
  );

  ////////////////////////////////////////////////////////////////////////////
  // Mode control
  always_comb begin
    st_d = st_q;
    case (st_q)
      dwdt_pkg::DWDT_RUN: begin
        if (trip) begin
          st_d = dwdt_pkg::DWDT_RESETTING;
        end else if (stop_exec & stop_ok) begin
          st_d = dwdt_pkg::DWDT_STOPPED;
        end
      end
      dwdt_pkg::DWDT_STOPPED: begin
        if (wake_irq) begin
          st_d = dwdt_pkg::DWDT_RUN;
        end
      end
      dwdt_pkg::DWDT_RESETTING: begin
        if (!hold_rst) begin
          st_d = dwdt_pkg::DWDT_RUN;
        end
      end
      default: st_d = dwdt_pkg::DWDT_RUN;
    endcase
  end

  always_ff @(posedge ref_clk) begin
    if (reset) begin
      st_q <= dwdt_pkg::DWDT_RUN;
    end else begin
      st_q <= st_d;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Counter, prescaler and activation
  always_ff @(posedge ref_clk) begin
    if (reset || st_q == dwdt_pkg::DWDT_RESETTING) begin
      cnt_q <= dwdt_to_cnt(RST_VAL);
      act_q <= RST_VAL[`DWDT_BIT_ACT];
      pre_q <= '0;
    end else begin
      if (reg_wr) begin
        cnt_q <= cnt_wr;
        pre_q <= '0;
        act_q <= act_q | wr_data[`DWDT_BIT_ACT];
      end else if (pre_tick) begin
        cnt_q <= cnt_dec;
        pre_q <= '0;
      end else if (!frozen) begin
        pre_q <= pre_q + PW'(1);
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Outputs
  always_ff @(posedge ref_clk) begin
    if (reset) begin
      rd_data <= 8'h00;
    end else if (rd_en && reg_sel) begin
      rd_data <= dwdt_to_reg(cnt_q, active);
    end
  end

  assign rd_hit    = rd_en & reg_sel;
  assign osc_stop  = frozen;
  assign core_wait = (st_q == dwdt_pkg::DWDT_RUN) & stop_exec & ~stop_ok;
  assign wdt_reset = (st_q == dwdt_pkg::DWDT_RESETTING) | trip;
endmodule : dwdt_watchdog

// [dwdt_watchdog_properties.sv]
module dwdt_watchdog_chk #(
  parameter int RESET_DELAY = 8
) (
  input wire logic       ref_clk,
  input wire logic       reset,
  input wire logic       hw_activation,
  input wire logic       ext_stop_ctrl,
  input wire logic       nmi_pin,
  input wire logic       stop_exec,
  input wire logic       wake_irq,
  input wire logic [7:0] addr,
  input wire logic       wr_en,
  input wire logic [7:0] wr_data,
  input wire logic       osc_stop,
  input wire logic       core_wait,
  input wire logic       wdt_reset
);
  timeunit 1ns;
  timeprecision 1ns;
  default clocking @(posedge ref_clk); endclocking
  default disable iff (reset);
  trip_hold_a: assert property ($rose(wdt_reset) |-> wdt_reset [*8]) else $error("short");
  trip_release_a: assert property ($rose(wdt_reset) |-> ##RESET_DELAY wdt_reset ##[1:2]
    !wdt_reset) else $error("release");
  sr_write_a: assert property (hw_activation && wr_en && addr == 8'hd8 && !wr_data[1]
    |-> wdt_reset) else $error("sr write");
  stop_wait_a: assert property (stop_exec && hw_activation && !ext_stop_ctrl && !wdt_reset
    |-> core_wait ##1 !osc_stop) else $error("wait");
  nmi_wait_a: assert property (stop_exec && hw_activation && !nmi_pin && !wdt_reset
    |-> core_wait) else $error("nmi wait");
  freeze_a: assert property (stop_exec && ext_stop_ctrl && nmi_pin && !osc_stop
    && !wdt_reset |-> !core_wait ##1 osc_stop) else $error("freeze");
  wake_a: assert property (osc_stop && wake_irq |=> !osc_stop) else $error("wake");
  frozen_a: assert property (osc_stop && !wake_irq |=> osc_stop && !wdt_reset)
    else $error("frozen");
endmodule : dwdt_watchdog_chk

// [dwdt_core_model.sv]
module dwdt_core_model (
  input  wire logic ref_clk,
  input  wire logic stop_cmd,
  input  wire logic wake_cmd,
  output logic      stop_exec,
  output logic      wake_irq
);
  timeunit 1ns;
  timeprecision 1ns;
  logic stop_q;
  logic wake_q;
  // One-cycle pulse per command, as a single STOP or interrupt
  assign stop_exec = stop_cmd & ~stop_q;
  assign wake_irq  = wake_cmd & ~wake_q;
  always_ff @(posedge ref_clk) begin
    stop_q <= stop_cmd;
    wake_q <= wake_cmd;
  end
endmodule : dwdt_core_model

// [dwdt_watchdog_test.sv]
module dwdt_watchdog_test;
  timeunit 1ns;
  timeprecision 1ns;
  logic       ref_clk = '0, reset = 1'h1, hw = '0, ext = '0, nmi = '0, stp = '0, wk = '0;
  logic       wr_en = '0, rd_en = '0, stop_exec, wake_irq, rd_hit, osc_stop, core_wait, wdt_reset;
  logic [7:0] addr = 8'hd8, wr_data = '0, rd_data;
  int         failures = 0, total_checks = 0;
  always #10 ref_clk = ~ref_clk;
  dwdt_watchdog #(.PRESCALE(4), .RESET_DELAY(8)) u_dwdt_watchdog (.*, .hw_activation(hw),
    .ext_stop_ctrl(ext), .nmi_pin(nmi));
  dwdt_core_model u_dwdt_core_model (.ref_clk, .stop_cmd(stp), .wake_cmd(wk), .stop_exec,
    .wake_irq);
  task automatic chk(string name, logic [7:0] exp, logic [7:0] got);
    total_checks++;
    if (got !== exp) begin
      failures++;
      $display("MISMATCH %s exp %h got %h", name, exp, got);
    end
  endtask : chk
  function automatic logic [7:0] enc(int n, logic act);
    return {n[0], n[1], n[2], n[3], n[4], n[5], n[6], act};
  endfunction : enc
  task automatic rst(logic h, logic e);
    @(posedge ref_clk);
    reset <= 1'h1;
    hw    <= h;
    ext   <= e;
    repeat (8) @(posedge ref_clk);
    reset <= '0;
  endtask : rst
  task automatic wr(logic [7:0] d);
    @(posedge ref_clk);
    wr_en   <= 1'h1;
    wr_data <= d;
    @(posedge ref_clk);
    wr_en <= '0;
  endtask : wr
  task automatic rd(logic [7:0] e);
    @(posedge ref_clk);
    rd_en <= 1'h1;
    @(posedge ref_clk);
    rd_en <= '0;
    #1 chk("register", e, rd_data);
  endtask : rd
  task automatic st(logic n, logic [1:0] e);
    logic cw;
    @(posedge ref_clk);
    nmi <= n;
    stp <= 1'h1;
    #5 cw = core_wait;
    @(posedge ref_clk);
    stp <= '0;
    #1 chk("stop", {6'h0, e}, {6'h0, cw, osc_stop});
  endtask : st
  task automatic trip(logic e);
    #1 chk("wdt_reset", {7'h0, e}, {7'h0, wdt_reset});
  endtask : trip
  task automatic finish_test();
    $display("checks %0d failures %0d", total_checks, failures);
    if (failures == 0 && total_checks > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask : finish_test
  initial begin
    #100000 failures++;
    finish_test();
  end
  initial begin
    rst(0, 0);
    rd(8'hfe);
    wr(enc(2, 0));
    repeat (20) @(posedge ref_clk);
    trip(0);
    rd(enc(125, 0));
    wr(enc(65, 1));
    rd(enc(65, 1));
    wr(enc(65, 0));
    rd(enc(65, 1));
    repeat (3) @(posedge ref_clk);
    trip(0);
    repeat (5) @(posedge ref_clk);
    trip(1);
    repeat (12) @(posedge ref_clk);
    rd(enc(126, 0));
    rst(1, 0);
    rd(8'hff);
    wr(8'hfe);
    rd(8'hff);
    st(1, 2'b10);
    rst(1, 1);
    st(0, 2'b10);
    wr(enc(65, 1));
    st(1, 2'b01);
    repeat (40) @(posedge ref_clk);
    rd(enc(65, 1));
    @(posedge ref_clk);
    wk <= 1'h1;
    repeat (12) @(posedge ref_clk);
    trip(1);
    repeat (12) @(posedge ref_clk);
    wr(8'hfd);
    trip(1);
    finish_test();
  end
endmodule : dwdt_watchdog_test
bind dwdt_watchdog dwdt_watchdog_chk #(.RESET_DELAY(RESET_DELAY)) u_dwdt_watchdog_chk (.*);
